// ==== rtl/frt_pkg.sv ====
/*
 * Constants of the capture/compare timer: register map, field positions,
 * reset values and prescaler divisors.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package frt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int CAP_CH = 2;
    localparam int CMP_CH = 4;
    localparam int PIN_N = 2;
    localparam int STAT_W = 8;
    localparam int PRE_W = 6;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CAP_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CAP_A = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CAP_B = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CMP0 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CMP_CTRL = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h2C;

    // Control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_MODE_BIT = 2;
    localparam int CTRL_CLR_BIT = 3;
    localparam int CTRL_RUN_BIT = 4;
    localparam int CTRL_W = 5;
    // Capture control: two edge bits per channel, then transfer enables
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam int CAPC_XFER_LSB = 4;
    localparam int CAPC_W = 6;
    // Compare control: direct mode, direct level, channel enables
    localparam int CMPC_DIR_LSB = 0;
    localparam int CMPC_LVL_LSB = 2;
    localparam int CMPC_EN_LSB = 4;
    localparam int CMPC_W = 8;
    // Interrupt status and mask layout
    localparam int ST_OVF = 0;
    localparam int ST_MATCH0 = 1;
    localparam int ST_CAP_LSB = 2;
    localparam int ST_CMP_LSB = 4;

    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [CAPC_W-1:0] CAPC_RST = 6'h00;
    localparam logic [CMPC_W-1:0] CMPC_RST = 8'h00;
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [STAT_W-1:0] MASK_RST = 8'h00;

    localparam int DIV_SEL0 = 4;
    localparam int DIV_SEL1 = 16;
    localparam int DIV_SEL2 = 32;
    localparam int DIV_SEL3 = 64;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/timebase_if.sv ====
/*
 * Shared time base carried from the counter to the capture and compare units.
 * Assumes one clock; upd is high in the first cycle of each new count value.
 */
`timescale 1ns/1ns
interface timebase_if;
    logic [15:0] count;
    logic upd;
    modport src (output count, output upd);
    modport snk (input count, input upd);
endinterface

// ==== rtl/capture_unit.sv ====
/*
 * Edge capture channels: synchronise each pin, detect the selected edges and
 * latch the shared count.
 * Assumes pins are asynchronous to clk_i and the time base is on clk_i.
 */
`timescale 1ns/1ns
module capture_unit #(
    parameter int CH = 2
) (
    input wire logic clk_i, // Timer clock
    input wire logic rst_i, // Async reset, active high
    timebase_if.snk tb, // Shared count
    input wire logic [CH-1:0] pin_i, // Capture pins
    input wire logic [2*CH-1:0] edge_sel_i, // Rise/fall select per channel
    output logic [CH-1:0] event_o, // One-cycle capture pulse
    output logic [CH*16-1:0] data_o // Captured counts
);
    import frt_pkg::*;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            logic meta_r;
            logic sync_r;
            logic prev_r;
            logic trig;
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    meta_r <= pin_i[g];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign trig = (sync_r & ~prev_r & edge_sel_i[2*g+EDGE_RISE_BIT]) |
                          (~sync_r & prev_r & edge_sel_i[2*g+EDGE_FALL_BIT]);
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    event_o[g] <= 1'b0;
                    data_o[16*g +: 16] <= CNT_RST;
                end else begin
                    event_o[g] <= trig;
                    if (trig) begin
                        data_o[16*g +: 16] <= tb.count;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== rtl/compare_unit.sv ====
/*
 * Compare channels sharing one comparator by time slots.
 * Assumes each count value stands at least CH cycles, so every channel gets
 * one slot per value; the slot sequence restarts on each upd.
 */
`timescale 1ns/1ns
module compare_unit #(
    parameter int CH = 4
) (
    input wire logic clk_i, // Timer clock
    input wire logic rst_i, // Async reset, active high
    timebase_if.snk tb, // Shared count
    input wire logic [CH*16-1:0] cmp_val_i, // Compare values
    input wire logic [CH-1:0] cmp_en_i, // Channel enables
    output logic [CH-1:0] match_o // One-cycle match pulse per channel
);
    localparam int PW = $clog2(CH + 1);
    localparam logic [PW-1:0] DONE = PW'(CH);

    logic [PW-1:0] phase_r;
    logic [PW-1:0] cur;
    logic [15:0] sel_val;
    logic hit;

    assign cur = tb.upd ? '0 : phase_r;

    always_comb begin
        sel_val = '0;
        for (int k = 0; k < CH; k++) begin
            if (cur == PW'(k)) begin
                sel_val = cmp_val_i[16*k +: 16];
            end
        end
    end

    // One comparator serves all channels in turn
    assign hit = (cur != DONE) && (sel_val == tb.count);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r <= DONE;
        end else if (cur != DONE) begin
            phase_r <= cur + 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_m
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    match_o[g] <= 1'b0;
                end else begin
                    match_o[g] <= hit && cmp_en_i[g] && (cur == PW'(g));
                end
            end
        end
    endgenerate
endmodule

// ==== rtl/frt_timer.sv ====
/*
 * Free-running 16-bit timer with two capture channels and four compare
 * channels, registers on AXI4-Lite.
 * Assumes one clock MCLK_I, an AXI4-Lite master on the same clock, and
 * asynchronous capture pins.
 */
// Functional notes
// - Counter steps on machine clock divided by 4, 16, 32 or 64.
// - Timer interrupt on overflow, or on compare zero match in matching mode.
// - Counter clears on reset, software clear, or compare zero match.
// - Counter value is the common time base of capture and compare units.
// - Capture edge stores counter into channel register and requests interrupt.
// - Per capture channel, trigger on rising, falling or both edges.
// - Capture interrupt issued only when enabled for that channel.
// - Two capture pins, each with its own capture data register.
// - Each capture event can request the automatic transfer service.
// - One time-shared comparator; separate interrupt per matching channel.
// - Compare pin toggles on match or drives its direct-output bit.
// - Four compare channels make two independent output waveforms.
`timescale 1ns/1ns
module frt_timer (
    input wire logic MCLK_I, // Machine clock
    input wire logic RESET_I, // Async reset, active high
    input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write address
    input wire logic [2:0] S_AXI_AWPROT_I, // Unused
    input wire logic S_AXI_AWVALID_I, // Write address valid
    output logic S_AXI_AWREADY_O, // Write address ready
    input wire logic [frt_pkg::DATA_W-1:0] S_AXI_WDATA_I, // Write data
    input wire logic [3:0] S_AXI_WSTRB_I, // Byte enables
    input wire logic S_AXI_WVALID_I, // Write data valid
    output logic S_AXI_WREADY_O, // Write data ready
    output logic [1:0] S_AXI_BRESP_O, // Write response
    output logic S_AXI_BVALID_O, // Write response valid
    input wire logic S_AXI_BREADY_I, // Write response ready
    input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_ARADDR_I, // Read address
    input wire logic [2:0] S_AXI_ARPROT_I, // Unused
    input wire logic S_AXI_ARVALID_I, // Read address valid
    output logic S_AXI_ARREADY_O, // Read address ready
    output logic [frt_pkg::DATA_W-1:0] S_AXI_RDATA_O, // Read data
    output logic [1:0] S_AXI_RRESP_O, // Read response
    output logic S_AXI_RVALID_O, // Read data valid
    input wire logic S_AXI_RREADY_I, // Read data ready
    input wire logic CAPTURE_INPUT_A_I, // Capture pin A
    input wire logic CAPTURE_INPUT_B_I, // Capture pin B
    output logic [frt_pkg::PIN_N-1:0] COMPARE_OUT_O, // Waveform pins
    output logic [frt_pkg::CAP_CH-1:0] XFER_REQ_O, // Transfer request pulses
    output logic IRQ_O // Level interrupt
);
    import frt_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic [CAPC_W-1:0] capc_r;
    logic [CMPC_W-1:0] cmpc_r;
    logic [CNT_W-1:0] cmp_r [CMP_CH];
    logic [CMP_CH*16-1:0] cmp_flat;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_nxt;
    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;
    logic [STAT_W-1:0] mask_r;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_mask;
    logic [CNT_W-1:0] count_r;
    logic upd_r;
    logic clr_pend_r;
    logic tick;
    logic ovf;
    logic sw_clr;
    logic [CAP_CH-1:0] cap_evt;
    logic [CAP_CH*16-1:0] cap_data;
    logic [CMP_CH-1:0] match;

    logic aw_full_r;
    logic w_full_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic wr_hit;
    logic [DATA_W-1:0] bmask;
    logic ar_take;
    logic rd_hit;
    logic [DATA_W-1:0] rd_val;

    timebase_if tb_bus ();

    // Merge byte lanes of a write into the old value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v);
        merge = (old_v & ~bmask) | (wdata_r & bmask);
    endfunction

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[8*b +: 8] = {8{wstrb_r[b]}};
        end
    end

    function automatic logic is_off(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] o);
        is_off = ({a[ADDR_W-1:2], 2'b00} == o);
    endfunction

    // Prescaler: a tick each time the selected low bits are all ones
    always_comb begin
        case (ctrl_r[CTRL_SEL_LSB +: 2])
            2'b00: pre_mask = PRE_W'(DIV_SEL0 - 1);
            2'b01: pre_mask = PRE_W'(DIV_SEL1 - 1);
            2'b10: pre_mask = PRE_W'(DIV_SEL2 - 1);
            default: pre_mask = PRE_W'(DIV_SEL3 - 1);
        endcase
    end

    assign tick = ctrl_r[CTRL_RUN_BIT] && ((pre_r & pre_mask) == pre_mask);
    assign ovf = tick && !clr_pend_r && (count_r == {CNT_W{1'b1}});
    assign sw_clr = wr_go && is_off(waddr_r, OFF_CTRL) && wstrb_r[0] &&
                    wdata_r[CTRL_CLR_BIT];

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pre_r <= '0;
        end else if (!ctrl_r[CTRL_RUN_BIT]) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Counter: a compare-zero match clears at the next tick, so the
    // matching value still lasts one full count period.
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            count_r <= CNT_RST;
            upd_r <= 1'b0;
        end else begin
            upd_r <= sw_clr | tick;
            if (sw_clr) begin
                count_r <= CNT_RST;
            end else if (tick && clr_pend_r) begin
                count_r <= CNT_RST;
            end else if (tick) begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            clr_pend_r <= 1'b0;
        end else if (match[0] && ctrl_r[CTRL_MODE_BIT]) begin
            clr_pend_r <= 1'b1;
        end else if (tick || sw_clr) begin
            clr_pend_r <= 1'b0;
        end
    end

    assign tb_bus.count = count_r;
    assign tb_bus.upd = upd_r;

    generate
        for (genvar k = 0; k < CMP_CH; k++) begin : g_flat
            assign cmp_flat[16*k +: 16] = cmp_r[k];
        end
    endgenerate

    capture_unit #(.CH(CAP_CH)) u_cap (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .tb(tb_bus),
        .pin_i({CAPTURE_INPUT_B_I, CAPTURE_INPUT_A_I}),
        .edge_sel_i(capc_r[2*CAP_CH-1:0]),
        .event_o(cap_evt),
        .data_o(cap_data)
    );

    compare_unit #(.CH(CMP_CH)) u_cmp (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .tb(tb_bus),
        .cmp_val_i(cmp_flat),
        .cmp_en_i(cmpc_r[CMPC_EN_LSB +: CMP_CH]),
        .match_o(match)
    );

    // Pin p is toggled by channels 2p and 2p+1
    generate
        for (genvar p = 0; p < PIN_N; p++) begin : g_pin
            always_ff @(posedge MCLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    COMPARE_OUT_O[p] <= 1'b0;
                end else if (cmpc_r[CMPC_DIR_LSB + p]) begin
                    COMPARE_OUT_O[p] <= cmpc_r[CMPC_LVL_LSB + p];
                end else if (match[2*p] || match[2*p+1]) begin
                    COMPARE_OUT_O[p] <= ~COMPARE_OUT_O[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            XFER_REQ_O <= '0;
        end else begin
            XFER_REQ_O <= cap_evt & capc_r[CAPC_XFER_LSB +: CAP_CH];
        end
    end

    // Sticky events; a set in the clearing read's cycle survives
    always_comb begin
        stat_set = '0;
        stat_set[ST_OVF] = ovf;
        stat_set[ST_MATCH0] = match[0] && ctrl_r[CTRL_MODE_BIT];
        stat_set[ST_CAP_LSB +: CAP_CH] = cap_evt;
        stat_set[ST_CMP_LSB +: CMP_CH] = match;
        stat_clr = (ar_take && is_off(S_AXI_ARADDR_I, OFF_IRQ_STAT)) ? stat_r : '0;
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            stat_r <= '0;
            IRQ_O <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            IRQ_O <= |(stat_nxt & mask_r);
        end
    end

    // Write channel: address and data may arrive in either order
    assign wr_go = aw_full_r && w_full_r && !S_AXI_BVALID_O;
    assign wr_hit = is_off(waddr_r, OFF_CTRL) || is_off(waddr_r, OFF_COUNT) ||
                    is_off(waddr_r, OFF_CAP_CTRL) || is_off(waddr_r, OFF_CAP_A) ||
                    is_off(waddr_r, OFF_CAP_B) || is_off(waddr_r, OFF_CMP_CTRL) ||
                    is_off(waddr_r, OFF_IRQ_STAT) || is_off(waddr_r, OFF_IRQ_MASK) ||
                    ((waddr_r >= OFF_CMP0) && (waddr_r < OFF_CMP_CTRL));

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            aw_full_r <= 1'b0;
            waddr_r <= '0;
            S_AXI_AWREADY_O <= 1'b1;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_full_r <= 1'b1;
            waddr_r <= S_AXI_AWADDR_I;
            S_AXI_AWREADY_O <= 1'b0;
        end else if (wr_go) begin
            aw_full_r <= 1'b0;
        end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_AWREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            w_full_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            S_AXI_WREADY_O <= 1'b1;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_full_r <= 1'b1;
            wdata_r <= S_AXI_WDATA_I;
            wstrb_r <= S_AXI_WSTRB_I;
            S_AXI_WREADY_O <= 1'b0;
        end else if (wr_go) begin
            w_full_r <= 1'b0;
        end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_WREADY_O <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Software clear bit is a strobe and is not stored
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctrl_r <= CTRL_RST;
            capc_r <= CAPC_RST;
            cmpc_r <= CMPC_RST;
            mask_r <= MASK_RST;
        end else if (wr_go) begin
            if (is_off(waddr_r, OFF_CTRL)) begin
                ctrl_r <= CTRL_W'(merge(DATA_W'(ctrl_r))) & ~(CTRL_W'(1) << CTRL_CLR_BIT);
            end
            if (is_off(waddr_r, OFF_CAP_CTRL)) begin
                capc_r <= CAPC_W'(merge(DATA_W'(capc_r)));
            end
            if (is_off(waddr_r, OFF_CMP_CTRL)) begin
                cmpc_r <= CMPC_W'(merge(DATA_W'(cmpc_r)));
            end
            if (is_off(waddr_r, OFF_IRQ_MASK)) begin
                mask_r <= STAT_W'(merge(DATA_W'(mask_r)));
            end
        end
    end

    generate
        for (genvar k = 0; k < CMP_CH; k++) begin : g_cmpreg
            always_ff @(posedge MCLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    cmp_r[k] <= CMP_RST;
                end else if (wr_go && is_off(waddr_r, OFF_CMP0 + ADDR_W'(4*k))) begin
                    cmp_r[k] <= CNT_W'(merge(DATA_W'(cmp_r[k])));
                end
            end
        end
    endgenerate

    // Read channel: answer one cycle after the address is taken
    assign ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        if (is_off(S_AXI_ARADDR_I, OFF_CTRL)) begin
            rd_val = DATA_W'(ctrl_r);
        end else if (is_off(S_AXI_ARADDR_I, OFF_COUNT)) begin
            rd_val = DATA_W'(count_r);
        end else if (is_off(S_AXI_ARADDR_I, OFF_CAP_CTRL)) begin
            rd_val = DATA_W'(capc_r);
        end else if (is_off(S_AXI_ARADDR_I, OFF_CAP_A)) begin
            rd_val = DATA_W'(cap_data[15:0]);
        end else if (is_off(S_AXI_ARADDR_I, OFF_CAP_B)) begin
            rd_val = DATA_W'(cap_data[31:16]);
        end else if (is_off(S_AXI_ARADDR_I, OFF_CMP_CTRL)) begin
            rd_val = DATA_W'(cmpc_r);
        end else if (is_off(S_AXI_ARADDR_I, OFF_IRQ_STAT)) begin
            rd_val = DATA_W'(stat_r);
        end else if (is_off(S_AXI_ARADDR_I, OFF_IRQ_MASK)) begin
            rd_val = DATA_W'(mask_r);
        end else begin
            rd_hit = 1'b0;
            for (int k = 0; k < CMP_CH; k++) begin
                if (is_off(S_AXI_ARADDR_I, OFF_CMP0 + ADDR_W'(4*k))) begin
                    rd_val = DATA_W'(cmp_r[k]);
                    rd_hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= rd_val;
            S_AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
        end
    end
endmodule

// ==== tb/frt_timer_monitor.sv ====
/* Checker on the timer ports: bus handshakes and capture outputs.
   Assumes it is bound to frt_timer, whose ports it watches. */
`timescale 1ns/1ns
module frt_timer_monitor (
    input wire logic MCLK_I, RESET_I, // Clock, reset
    input wire logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O, // Write
    input wire logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, // Bus
    input wire logic S_AXI_RVALID_O, CAPTURE_INPUT_A_I, // Read valid, pin A
    input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_AWADDR_I, // Write address
    input wire logic [1:0] S_AXI_BRESP_O, XFER_REQ_O // Response, requests
);
    import frt_pkg::*;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    write_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O) else $error("write unanswered");
    write_done_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O
        && S_AXI_AWREADY_O && S_AXI_WREADY_O) else $error("write not closed");
    aw_block_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write ready early");
    read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read unanswered");
    ar_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("read early");
    bad_addr_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_AWADDR_I > 8'h2F
        |-> ##[1:2] S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR) else $error("no error");
    xfer_pulse_a: assert property (XFER_REQ_O[0] |=> !XFER_REQ_O[0])
        else $error("request too long");
    cap_sync_a: assert property (XFER_REQ_O[0] |->
        $past(CAPTURE_INPUT_A_I, 3) != $past(CAPTURE_INPUT_A_I, 6)) else $error("capture delay");
    cover property (XFER_REQ_O[1]);
    cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR);
    cover property (S_AXI_RVALID_O);
endmodule
bind frt_timer frt_timer_monitor frt_timer_monitor_i (.*);

// ==== tb/pulse_source.sv ====
/* Pulse sources on the two capture pins.
   Assumes the bench calls pulse; pins idle low. */
`timescale 1ns/1ns
module pulse_source (
    input wire logic clk_i, // Timer clock
    output logic [1:0] pin_o // Capture pins
);
    initial pin_o = 2'b00;
    task automatic pulse(input int ch, input int width);
        @(posedge clk_i);
        pin_o[ch] <= 1'b1;
        repeat (width) @(posedge clk_i);
        pin_o[ch] <= 1'b0;
        repeat (width) @(posedge clk_i);
    endtask
endmodule

// ==== tb/test_free_run_capture_compare_timer.sv ====
/* Bench for the capture/compare timer: registers, prescaler, compare, capture.
   Assumes the monitor and pulse_source are compiled with it. */
`timescale 1ns/1ns
module test_free_run_capture_compare_timer;
    import frt_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] s;} row_type;
    logic MCLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [2:0] S_AXI_AWPROT_I = 3'h0, S_AXI_ARPROT_I = 3'h0;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, d, c0;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
    logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
    logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, IRQ_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, COMPARE_OUT_O, XFER_REQ_O, pins, resp;
    wire logic CAPTURE_INPUT_A_I = pins[0];
    wire logic CAPTURE_INPUT_B_I = pins[1];
    int num_errors = 0, check_count = 0, cyc = 0, t0 = 0, ev[2] = '{0, 0};
    int div[4] = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, DIV_SEL3};
    row_type rows[6] = '{'{OFF_CAP_CTRL, 32'hFF, 32'h3F, RESP_OKAY},
        '{OFF_CMP0 + 8'h04, 32'hFFFF1234, 32'h1234, RESP_OKAY},
        '{OFF_CMP_CTRL, 32'h1A5, 32'hA5, RESP_OKAY}, '{OFF_COUNT, 32'h55, 32'h0, RESP_OKAY},
        '{OFF_CTRL, 32'hF, 32'h7, RESP_OKAY}, '{8'h30, 32'h1, 32'h0, RESP_SLVERR}};
    frt_timer frt_timer_i (.*);
    pulse_source pulse_source_i (.clk_i(MCLK_I), .pin_o(pins));
    always #50 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 2; i++) if (XFER_REQ_O[i] === 1'b1) ev[i] <= ev[i] + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report;
        end
    end
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        RESET_I <= 1'b1;
        repeat (5) @(posedge MCLK_I);
        RESET_I <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge MCLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= w;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        do begin
            @(posedge MCLK_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
        end while (S_AXI_BVALID_O !== 1'b1);
        resp = S_AXI_BRESP_O;
        S_AXI_BREADY_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge MCLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do begin
            @(posedge MCLK_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
        end while (S_AXI_RVALID_O !== 1'b1);
        d = S_AXI_RDATA_O;
        resp = S_AXI_RRESP_O;
        S_AXI_RREADY_I <= 1'b0;
    endtask
    task automatic pin_change;
        logic p = COMPARE_OUT_O[0];
        do @(posedge MCLK_I); while (COMPARE_OUT_O[0] === p);
    endtask
    initial begin
        do_reset;
        for (int a = 0; a < 48; a += 4) begin
            rd(8'(a));
            check_val("reset value", 32'h0, d);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            check_val("write resp", rows[i].s, resp);
            rd(rows[i].a);
            check_val("read resp", rows[i].s, resp);
            if (rows[i].s == RESP_OKAY) check_val("read data", rows[i].r, d);
        end
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr(OFF_CTRL, 32'h18 | 32'(s));
            t0 = cyc;
            rd(OFF_COUNT);
            c0 = d;
            while (cyc - t0 < 10 * div[s]) @(posedge MCLK_I);
            rd(OFF_COUNT);
            check_val("count step", 32'hA, d - c0);
        end
        $display("test prescaler done");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CMP0, 32'h5);
        wr(OFF_CMP0 + 8'h08, 32'h3);
        wr(OFF_CMP_CTRL, 32'h50);
        wr(OFF_IRQ_MASK, 32'h2);
        wr(OFF_CTRL, 32'h1C);
        pin_change;
        t0 = cyc;
        c0 = 32'(COMPARE_OUT_O[1]);
        pin_change;
        check_val("toggle period", 32'h18, cyc - t0);
        check_val("second pin toggle", c0 ^ 32'h1, 32'(COMPARE_OUT_O[1]));
        check_val("match irq", 32'h1, IRQ_O);
        rd(OFF_IRQ_STAT);
        check_val("match status", 32'h52, d & 32'h52);
        wr(OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge MCLK_I);
        check_val("masked irq", 32'h0, IRQ_O);
        for (int l = 0; l < 2; l++) begin
            wr(OFF_CMP_CTRL, 32'h2 | 32'(l << 3));
            repeat (2) @(posedge MCLK_I);
            check_val("direct level", 32'(l), COMPARE_OUT_O[1]);
        end
        $display("test compare done");
        wr(OFF_CTRL, 32'h0);
        rd(OFF_COUNT);
        c0 = d;
        rd(OFF_IRQ_STAT);
        for (int ch = 0; ch < 2; ch++) begin
            for (int m = 1; m < 4; m++) begin
                wr(OFF_CAP_CTRL, 32'h30 | 32'(m << 2 * ch));
                t0 = ev[ch];
                pulse_source_i.pulse(ch, 4 * m);
                check_val("events", t0 + (m & 1) + (m >> 1), ev[ch]);
            end
        end
        rd(OFF_CAP_A);
        check_val("capture a", c0, d);
        rd(OFF_CAP_B);
        check_val("capture b", c0, d);
        wr(OFF_IRQ_MASK, 32'hC);
        repeat (2) @(posedge MCLK_I);
        check_val("capture irq", 32'h1, IRQ_O);
        rd(OFF_IRQ_STAT);
        check_val("capture status", 32'hC, d);
        $display("test capture done");
        wr(OFF_CTRL, 32'h10);
        repeat (20) @(posedge MCLK_I);
        do_reset;
        rd(OFF_COUNT);
        check_val("count after reset", 32'h0, d);
        $display("test reset done");
        final_report;
    end
endmodule
